// ===== logic/serial_irq_status_crc.sv
/*
 * interrupt bookkeeping and crc result logic of one synchronous serial
 * channel, reached as an avalon-mm slave with waitrequest.
 * assumes the four sources and the serial bit stream come from logic on
 * core_clk; they pass no synchroniser.
 */
`timescale 1ns/1ps

`include "serial_irq_defines.svh"

module serial_irq_status_crc (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // avalon-mm slave
    input  wire logic [15:0]               address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic      [31:0]               readdata,
    output logic                           waitrequest,
    output logic      [1:0]                response,
    // source conditions from the channel
    input  wire serial_irq_pkg::irq_bits_t source,
    // serial bits shifted out and in
    input  wire serial_irq_pkg::crc_bit_t  tx_bit,
    input  wire serial_irq_pkg::crc_bit_t  rx_bit,
    // channel interrupt
    output logic                           channel_irq,
    output serial_irq_pkg::crc_ctrl_t      crc_ctrl
);

    typedef struct packed {
        serial_irq_pkg::irq_bits_t guard;
        serial_irq_pkg::irq_bits_t enable;
        serial_irq_pkg::crc_ctrl_t ctrl;
        logic [15:0]               crc_value;
        logic [31:0]               readdata;
        logic                      waitrequest;
        logic [1:0]                response;
        logic                      irq;
    } state_t;

    state_t                    state;
    state_t                    next_state;
    serial_irq_pkg::irq_bits_t sticky;
    serial_irq_pkg::irq_bits_t req;
    logic [3:0]                clear_bits;
    logic                      access;
    logic                      wr_lo;
    logic [13:0]               index;
    logic                      crc_bit;
    logic                      crc_step;

    // one-wait-state slave: waitrequest drops in the cycle after the request
    assign access     = (read | write) & state.waitrequest;
    assign index      = address[15:2];
    assign wr_lo      = write & access & byteenable[0];
    assign clear_bits = (wr_lo && index == 14'(`IRQ_STICKY_IDX)) ? writedata[3:0] : 4'h0;

    // sources wired in the documented bit order
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            irq_edge_sticky u_src (
                .core_clk     (core_clk),
                .sys_rst      (sys_rst),
                .source       (source[g]),
                .clear_strobe (clear_bits[g]),
                .clear_guard  (state.guard[g]),
                .irq_en       (next_state.enable[g]),
                .sticky       (sticky[g]),
                .req          (req[g])
            );
        end
    endgenerate

    // crc input follows the direction select: zero transmit, one receive
    assign crc_bit   = state.ctrl.crc_direction_select ? rx_bit.data  : tx_bit.data;
    assign crc_step  = state.ctrl.crc_direction_select ? rx_bit.valid : tx_bit.valid;

    // register file, crc accumulator and interrupt output
    always_comb begin
        logic fb;
        logic [15:0] c;
        fb         = 1'b0;
        c          = state.crc_value;
        next_state = state;
        next_state.waitrequest = 1'b1;
        next_state.response    = 2'b00;
        next_state.readdata    = 32'h0000_0000;
        if (access) begin
            next_state.waitrequest = 1'b0;
            if (read) begin
                unique case (index)
                    14'(`CRC_RESULT_IDX):  next_state.readdata = {16'h0000, state.crc_value};
                    14'(`IRQ_STICKY_IDX):  next_state.readdata = {28'h000_0000, sticky};
                    14'(`IRQ_GUARD_IDX):   next_state.readdata = {28'h000_0000, state.guard};
                    14'(`IRQ_ENABLE_IDX):  next_state.readdata = {28'h000_0000, state.enable};
                    14'(`IRQ_REQUEST_IDX): next_state.readdata = {28'h000_0000, req};
                    14'(`CRC_CONTROL_IDX): next_state.readdata = {29'h0000_0000, state.ctrl};
                    default:               next_state.response = 2'b10;
                endcase
            end else if (wr_lo) begin
                unique case (index)
                    14'(`IRQ_GUARD_IDX):   next_state.guard  = writedata[3:0];
                    14'(`IRQ_ENABLE_IDX):  next_state.enable = writedata[3:0];
                    14'(`CRC_CONTROL_IDX): next_state.ctrl   = writedata[2:0];
                    14'(`CRC_RESULT_IDX), 14'(`IRQ_STICKY_IDX), 14'(`IRQ_REQUEST_IDX): begin
                    end
                    default:               next_state.response = 2'b10;
                endcase
            end
        end
        // accumulate one bit per shifted bit; msb-first lfsr
        if (crc_step) begin
            if (state.ctrl.crc_poly_select) begin
                fb = c[15] ^ crc_bit;
                c  = {c[14:0], 1'b0} ^ (fb ? `CRC16_POLY : 16'h0000);
            end else begin
                fb = c[6] ^ crc_bit;
                c  = {9'h000, c[5:0], 1'b0} ^ {9'h000, (fb ? `CRC7_POLY : 7'h00)};
            end
        end
        next_state.crc_value = c;
        // writing initialise from zero to one clears the accumulator
        if (next_state.ctrl.crc_initialise && !state.ctrl.crc_initialise) begin
            next_state.crc_value = `CRC_RESET;
        end
        next_state.irq = |req;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state             <= '0;
            state.waitrequest <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign readdata    = state.readdata;
    assign waitrequest = state.waitrequest;
    assign response    = state.response;
    assign channel_irq = state.irq;
    assign crc_ctrl    = state.ctrl;

    sequence guard_set_s;
        wr_lo && index == 14'(`IRQ_GUARD_IDX) && writedata[0];
    endsequence
    sequence clear_rx_s;
        clear_bits[0] && !(source[0] && !$past(source[0]));
    endsequence

    irq_output_or_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ##1 channel_irq == $past(|req))
        else $error("interrupt output not or of requests");
    request_gating_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (req & ~state.enable) == 4'h0)
        else $error("request set while disabled");
    upper_read_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (access && read && index == 14'(`IRQ_STICKY_IDX)) |=> readdata[31:4] == 28'h000_0000)
        else $error("upper status bits not zero");
    guard_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        guard_set_s |=> state.guard[0])
        else $error("guard write lost");
    guarded_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clear_rx_s and state.guard[0]) |=> !sticky[0])
        else $error("guarded clear failed");
    unguarded_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sticky[1] && !state.guard[1]) |=> sticky[1])
        else $error("status cleared with guard low");
    enable_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_lo && index == 14'(`IRQ_ENABLE_IDX)) |=> state.enable == $past(writedata[3:0]))
        else $error("enable write lost");
    crc_init_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (next_state.ctrl.crc_initialise && !state.ctrl.crc_initialise) |=> state.crc_value == 16'h0000)
        else $error("crc not initialised");
    crc7_width_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!state.ctrl.crc_poly_select && state.crc_value[15:7] == 9'h000) |=> state.crc_value[15:7] == 9'h000)
        else $error("crc7 used upper bits");
    answer_time_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("slave answer late");

endmodule

// ===== logic/serial_irq_defines.svh
/*
 * register offsets, field positions, reset values and crc polynomials for
 * the serial channel interrupt and crc block.
 * assumes a 32-bit avalon-mm slave with byte addresses; printed offsets are
 * register indices, so the byte address is four times the index.
 */
`ifndef SERIAL_IRQ_DEFINES_SVH
`define SERIAL_IRQ_DEFINES_SVH

// register indices as printed
`define CRC_RESULT_IDX        12'h0c06
`define IRQ_STICKY_IDX        12'h0c08
`define IRQ_GUARD_IDX         12'h0c0a
`define IRQ_ENABLE_IDX        12'h0c0c
`define IRQ_REQUEST_IDX       12'h0c0e
// crc control word, an index of our own in the free slot below the result
`define CRC_CONTROL_IDX       12'h0c04

// source bit positions
`define SRC_TX_SHIFT_EMPTY    3
`define SRC_RX_SHIFT_FULL     2
`define SRC_TX_BUF_EMPTY      1
`define SRC_RX_BUF_FULL       0

// crc control field positions
`define CTL_POLY_BIT          0
`define CTL_DIR_BIT           1
`define CTL_INIT_BIT          2

// reset values
`define IRQ_FIELD_RESET       4'h0
`define CRC_RESET             16'h0000

// polynomials: x16+x12+x5+1 and x7+x3+1
`define CRC16_POLY            16'h1021
`define CRC7_POLY             7'h09

`endif

// ===== logic/serial_irq_pkg.sv
/*
 * types shared by the serial channel interrupt and crc block.
 * assumes the defines header for numbers; only types live here.
 */
package serial_irq_pkg;

    // one bit per interrupt source, same layout in every register
    typedef struct packed {
        logic tx_shift_empty;
        logic rx_shift_full;
        logic tx_buf_empty;
        logic rx_buf_full;
    } irq_bits_t;

    // serial bit fed into the crc accumulator
    typedef struct packed {
        logic valid;
        logic data;
    } crc_bit_t;

    // crc control bits
    typedef struct packed {
        logic crc_initialise;
        logic crc_direction_select;
        logic crc_poly_select;
    } crc_ctrl_t;

endpackage

// ===== logic/irq_edge_sticky.sv
/*
 * one interrupt source: edge detector, sticky bit with guarded
 * write-one-to-clear, and the gated request.
 * assumes the source is synchronous to core_clk.
 */
`timescale 1ns/1ps

module irq_edge_sticky (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic source,
    input  wire logic clear_strobe,
    input  wire logic clear_guard,
    input  wire logic irq_en,
    output logic      sticky,
    output logic      req
);

    typedef struct packed {
        logic prev;
        logic sticky;
        logic req;
    } state_t;

    state_t state;
    state_t next_state;
    logic   rise;

    assign rise = source & ~state.prev;

    // a rising edge in the clearing cycle wins over the clear
    always_comb begin
        next_state        = state;
        next_state.prev   = source;
        if (clear_strobe && clear_guard) begin
            next_state.sticky = 1'b0;
        end
        if (rise) begin
            next_state.sticky = 1'b1;
        end
        next_state.req    = next_state.sticky & irq_en;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sticky = state.sticky;
    assign req    = state.req;

    edge_sets_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rise |=> sticky)
        else $error("edge did not set sticky bit");
    guard_blocks_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sticky && !clear_guard && !rise) |=> sticky)
        else $error("sticky cleared without guard");
    req_gated_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!irq_en) |=> (!req || $past(irq_en, 1) == 1'b0 && irq_en))
        else $error("request without enable");

endmodule

// ===== tb/serial_irq_status_crc_tb_top.sv
/*
 * self-checking bench for serial_irq_status_crc: bus reads and writes, source events,
 * guarded clears, masking and crc accumulation against an integer model.
 * assumes the design's defines header is on the include path.
 */
`timescale 1ns/1ps
`include "serial_irq_defines.svh"
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("mismatch at %0t: %s", $time, msg); end end

module serial_irq_status_crc_tb_top;
    logic                      core_clk = 1'b0;
    logic                      sys_rst;
    logic [15:0]               address;
    logic                      read;
    logic                      write;
    logic [31:0]               writedata;
    logic [3:0]                byteenable;
    logic [31:0]               readdata;
    logic                      waitrequest;
    logic [1:0]                response;
    serial_irq_pkg::irq_bits_t source;
    serial_irq_pkg::crc_bit_t  tx_bit;
    serial_irq_pkg::crc_bit_t  rx_bit;
    logic                      channel_irq;
    serial_irq_pkg::crc_ctrl_t crc_ctrl;
    int                        n_fail = 0;
    int                        comparisons = 0;
    int                        sticky_m;
    int                        en_m;
    int                        guard_m;
    int                        prev_m;
    int                        crc_m;
    logic [31:0]               rd;
    logic [1:0]                rsp;
    logic                      p;
    logic                      d;
    logic                      b;
    logic                      o;

    always #20 core_clk = ~core_clk;

    serial_irq_status_crc u_serial_irq_status_crc (
        .core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .source(source), .tx_bit(tx_bit), .rx_bit(rx_bit),
        .channel_irq(channel_irq), .crc_ctrl(crc_ctrl));

    task automatic results;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // one avalon access; request held until waitrequest is seen low at an edge
    // no cycle count is assumed: only the watchdog ends a wait that never ends
    task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        @(posedge core_clk);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= wd;
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rdchk(input logic [13:0] idx, input int exp);
        bus(1'b0, idx, 32'h0000_0000);
        `CHK(rd, 32'(exp), "register read value")
        `CHK(rsp, 2'b00, "read response")
    endtask

    // the model records rises only, so a held level never re-arms a cleared bit
    task automatic set_src(input int v);
        @(posedge core_clk);
        source <= 4'(v);
        sticky_m |= v & ~prev_m;
        prev_m = v;
        repeat (2) @(posedge core_clk);
    endtask

    // msb-first crc step; crc7 keeps the upper bits at zero
    function automatic int step(input int c, input logic bi, input logic p16);
        int fb;
        fb = (p16 ? (c >> 15) : (c >> 6)) & 1;
        fb ^= bi;
        c = (c << 1) & (p16 ? 32'h0000_ffff : 32'h0000_007f);
        if (fb != 0) c ^= p16 ? `CRC16_POLY : `CRC7_POLY;
        return c;
    endfunction

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        {address, read, write, writedata} = '0;
        byteenable = 4'hf;
        source = '0;
        tx_bit = '0;
        rx_bit = '0;
        {sticky_m, en_m, guard_m, prev_m} = '0;
        void'($urandom(32'hc3d0267a));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(`IRQ_STICKY_IDX, 0);
        rdchk(`IRQ_GUARD_IDX, 0);
        rdchk(`IRQ_ENABLE_IDX, 0);
        rdchk(`IRQ_REQUEST_IDX, 0);
        rdchk(`CRC_RESULT_IDX, 0);
        bus(1'b0, 14'h0c20, 32'h0000_0000);
        `CHK(rsp, 2'b10, "unmapped read response")
        // read-only places must ignore writes
        bus(1'b1, `IRQ_REQUEST_IDX, 32'h0000_000f);
        bus(1'b1, `CRC_RESULT_IDX, 32'h0000_ffff);
        rdchk(`IRQ_REQUEST_IDX, 0);
        rdchk(`CRC_RESULT_IDX, 0);
        for (int i = 0; i < 16; i++) begin
            set_src($urandom & 15);
            rdchk(`IRQ_STICKY_IDX, sticky_m);
            en_m = $urandom & 15;
            bus(1'b1, `IRQ_ENABLE_IDX, 32'(en_m));
            rdchk(`IRQ_ENABLE_IDX, en_m);
            rdchk(`IRQ_REQUEST_IDX, sticky_m & en_m);
            `CHK(channel_irq, ((sticky_m & en_m) != 0), "channel irq level")
            bus(1'b1, `IRQ_STICKY_IDX, 32'hffff_ffff);
            sticky_m &= ~guard_m;
            guard_m = $urandom & 15;
            bus(1'b1, `IRQ_GUARD_IDX, 32'(guard_m));
            rdchk(`IRQ_GUARD_IDX, guard_m);
            bus(1'b1, `IRQ_STICKY_IDX, 32'hffff_ffff);
            sticky_m &= ~guard_m;
            rdchk(`IRQ_STICKY_IDX, sticky_m);
        end
        // a write without the low byte lane must leave the enables alone
        byteenable <= 4'he;
        bus(1'b1, `IRQ_ENABLE_IDX, 32'(~en_m));
        byteenable <= 4'hf;
        rdchk(`IRQ_ENABLE_IDX, en_m);
        // every poly and direction; the unselected stream carries noise
        for (int m = 0; m < 4; m++) begin
            p = m[0];
            d = m[1];
            // drop the shift empty source so that its end of transfer rise is seen
            set_src(0);
            bus(1'b1, `CRC_CONTROL_IDX, {30'h0, d, p});
            bus(1'b1, `CRC_CONTROL_IDX, {29'h0, 1'b1, d, p});
            @(posedge core_clk);
            `CHK(crc_ctrl, {1'b1, d, p}, "crc control copy")
            crc_m = 0;
            for (int k = 0; k < 24; k++) begin
                b = 1'($urandom);
                o = 1'($urandom);
                @(posedge core_clk);
                tx_bit <= {1'b1, d ? o : b};
                rx_bit <= {1'b1, d ? b : o};
                crc_m = step(crc_m, b, p);
            end
            @(posedge core_clk);
            tx_bit <= '0;
            rx_bit <= '0;
            repeat (2) @(posedge core_clk);
            // transfer done: poll the shift empty status before taking the crc
            set_src(8);
            do begin
                bus(1'b0, `IRQ_STICKY_IDX, 32'h0000_0000);
            end while (rd[3] !== 1'b1);
            rdchk(`CRC_RESULT_IDX, crc_m);
        end
        results();
    end
endmodule
